// ==== gpib_pipe_regs.vh ====
// register offsets, field positions, sizes and character codes of the command pipeline
`ifndef GPIB_PIPE_REGS_VH
`define GPIB_PIPE_REGS_VH

// ----
// register byte offsets
// ----
`define ADR_ESR    8'h00
`define ADR_ESE    8'h04
`define ADR_SRE    8'h08
`define ADR_PPE    8'h0c
`define ADR_STB    8'h10
`define ADR_STATE  8'h14

// ----
// reset values
// ----
`define RST_MASK   8'h00
`define RST_VALUE  8'h00

// ----
// event status bits
// ----
`define ESR_OPC    0
`define ESR_QYE    2
`define ESR_EXE    4
`define ESR_CME    5

// ----
// status byte bits
// ----
`define STB_QUES   3
`define STB_MAV    4
`define STB_ESB    5
`define STB_MSS    6
`define STB_OPER   7
`define STB_NO_MSS 8'hbf

// ----
// buffer sizes
// ----
`define IBUF_DEPTH 9'h100
`define OBUF_DEPTH 13'h1000

// ----
// character codes and headers
// ----
`define CH_NL      8'h0a
`define CH_SEMI    8'h3b
`define CH_QM      8'h3f
`define CH_HASH    8'h23
`define CH_ZERO    8'h30
`define CH_ONE     8'h31
`define CH_WS_LO   8'h09
`define CH_WS_MID  8'h0b
`define CH_WS_HI   8'h20
`define HDR_OPC    32'h2a4f_5043
`define HDR_WAI    32'h2a57_4149
`define HDR_VAL    32'h0056_414c

`endif

// ==== gpib_cmd_pipeline.v ====
// remote command pipeline: input buffer, parser, settings store, output buffer, status
// Function
// [R1] received bytes collected one by one in a 256-entry input buffer
// [R2] buffered data released to parser on full, terminator or device clear; on device clear the code empties the buffer instead of releasing it
// [R3] when input buffer full, bus handshake held off until parser drains it
// [R4] after a terminator the next line is accepted while parsing continues
// [R5] device clear empties the input buffer and immediately signals the parser
// [R6] parser works strictly in arrival order; trigger only after earlier commands
// [R7] each recognised setting is staged at once without touching the hardware
// [R8] syntax errors reported; parsing resumes after the faulty command
// [R9] terminator or device clear applies staged settings while parsing goes on
// [R10] settings checked before apply; failure flags execution error and reverts
// [R11] a query sends the requested value to the output buffer
// [R12] responses held in a 4096-entry output buffer, drained in portions
// [R13] talk with nothing buffered or pending raises query error, sends nothing
// [R14] after *OPC the operation-complete event bit sets once hardware settled
// [R15] after *OPC? a character 1 enters the output buffer once settled
// [R16] after *WAI the bus handshake is withheld until hardware settled
// [R17] settled indication gates the *OPC, *OPC? and *WAI actions
// [R18] controller needing strict order sends each command on its own line
// [R19] codes 0 to 9 and 11 to 32 are white space before a parameter
// [R20] hash character opens a block data parameter
// [R21] status byte with request mask fed by event, operation, questionable sums
// [R22] message-available bit follows output buffer occupancy
// [R23] individual status bit is the status byte masked by parallel poll enable
// [R24] newline, newline with end flag, or end flag on last byte terminate
// [R25] block length digits give an exact raw byte count, terminators ignored
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "gpib_pipe_regs.vh"

module gpib_cmd_pipeline (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        rx_valid_i,
   input  wire [7:0]  rx_data_i,
   input  wire        rx_eoi_i,
   output wire        rx_ready_o,
   input  wire        dcl_i,
   input  wire        get_i,
   input  wire        talk_i,
   output wire        tx_valid_o,
   output reg  [7:0]  tx_data_o,
   input  wire        tx_ready_i,
   input  wire        hw_settled_i,
   input  wire        hw_check_ok_i,
   output reg  [7:0]  hw_staged_o,
   output reg  [7:0]  hw_value_o,
   output reg         hw_apply_o,
   output reg         trigger_o,
   input  wire        oper_sum_i,
   input  wire        ques_sum_i,
   output reg         srq_o,
   output reg         ist_o
);

   localparam [2:0] S_HDR  = 3'd0;
   localparam [2:0] S_PAR  = 3'd1;
   localparam [2:0] S_BN   = 3'd2;
   localparam [2:0] S_BL   = 3'd3;
   localparam [2:0] S_BD   = 3'd4;
   localparam [2:0] S_SKIP = 3'd5;

   function [7:0] hexc;
      input [3:0] n;
      begin
         if (n < 4'ha)
            hexc = 8'h30 + {4'h0, n};
         else
            hexc = 8'h37 + {4'h0, n};
      end
   endfunction

   // ----------------------------------------------------------------------------
   // input buffer
   // ----------------------------------------------------------------------------
   reg  [9:0]  ibuf [0:255];
   reg  [7:0]  iwr_q;
   reg  [7:0]  ird_q;
   reg  [8:0]  icnt_q;
   reg  [8:0]  avail_q;
   reg         wai_q;
   reg         opc_q;
   reg         opcq_q;
   reg  [1:0]  rn_q;
   reg  [23:0] resp_q;
   wire        pstall = (rn_q != 2'd0) | wai_q | opcq_q;
   wire        ifull  = (icnt_q == `IBUF_DEPTH);
   // [R3] hold off when full
   // [R16] handshake withheld during wait
   assign rx_ready_o = ~ifull & ~wai_q & ~get_i;
   wire        ipush  = ((rx_valid_i & rx_ready_o) | get_i) & ~ifull & ~dcl_i;
   wire [9:0]  ient   = get_i ? 10'h200 : {1'b0, rx_eoi_i, rx_data_i};
   wire        iterm  = get_i | rx_eoi_i | (rx_data_i == `CH_NL);
   wire        ipop   = (avail_q != 9'd0) & ~pstall & ~dcl_i;
   wire [8:0]  icnt_d = icnt_q + {8'h00, ipush} - {8'h00, ipop};
   // [R2] release on terminator or full
   wire        commit = ipush & (iterm | (icnt_d == `IBUF_DEPTH));

   // [R1] byte store
   always @(posedge clk_i)
   begin
      if (ipush)
         ibuf[iwr_q] <= ient;
   end

   always @(posedge clk_i)
   begin
      // [R5] clear discards contents
      if (rst_i | dcl_i)
      begin
         iwr_q   <= 8'h00;
         ird_q   <= 8'h00;
         icnt_q  <= 9'h000;
         avail_q <= 9'h000;
      end
      else
      begin
         if (ipush)
            iwr_q <= iwr_q + 8'h01;
         if (ipop)
            ird_q <= ird_q + 8'h01;
         icnt_q <= icnt_d;
         // [R4] later bytes accepted while earlier ones parse
         if (commit)
            avail_q <= icnt_d;
         else
            avail_q <= avail_q - {8'h00, ipop};
      end
   end

   // ----------------------------------------------------------------------------
   // parser
   // ----------------------------------------------------------------------------
   reg  [2:0]  pst_q, pst_d;
   reg  [31:0] hdr_q, hdr_d;
   reg         qry_q, qry_d;
   reg  [7:0]  val_q, val_d;
   reg         hasp_q, hasp_d;
   reg  [15:0] blen_q, blen_d;
   reg  [3:0]  bdig_q, bdig_d;
   reg         exec, perr, pterm, trig;

   // [R6] one entry at a time from the head
   wire [9:0]  cur    = ibuf[ird_q];
   wire [7:0]  c      = cur[7:0];
   wire        c_eoi  = cur[8];
   wire        c_get  = cur[9];
   // [R19] white space codes
   wire        c_ws   = (c <= `CH_WS_LO) | ((c >= `CH_WS_MID) & (c <= `CH_WS_HI));
   wire        c_sep  = (c == `CH_SEMI) | (c == `CH_NL);
   wire        c_dig  = (c >= `CH_ZERO) & (c <= 8'h39);
   wire [7:0]  upc    = ((c >= 8'h61) & (c <= 8'h7a)) ? (c - 8'h20) : c;
   wire [7:0]  val_x  = {val_q[4:0], 3'b000} + {val_q[6:0], 1'b0} + {4'h0, c[3:0]};
   wire [15:0] blen_x = {blen_q[12:0], 3'b000} + {blen_q[14:0], 1'b0} + {12'h000, c[3:0]};

   always @*
   begin
      pst_d  = pst_q;
      hdr_d  = hdr_q;
      qry_d  = qry_q;
      val_d  = val_q;
      hasp_d = hasp_q;
      blen_d = blen_q;
      bdig_d = bdig_q;
      exec   = 1'b0;
      perr   = 1'b0;
      pterm  = 1'b0;
      trig   = 1'b0;
      if (ipop)
      begin
         // [R6] trigger acts only in stream order
         if (c_get)
            trig = 1'b1;
         else
         begin
            case (pst_q)
               S_HDR:
               begin
                  if (!c_sep)
                  begin
                     if (c_ws)
                     begin
                        if ((hdr_q != 32'h0000_0000) | qry_q)
                           pst_d = S_PAR;
                     end
                     else if (c == `CH_QM)
                        qry_d = 1'b1;
                     else
                        hdr_d = {hdr_q[23:0], upc};
                  end
                  exec = c_sep | c_eoi;
               end
               S_PAR:
               begin
                  if (!c_sep)
                  begin
                     // [R20] block data opener
                     if (c == `CH_HASH)
                        pst_d = S_BN;
                     else if (c_dig)
                     begin
                        val_d  = val_x;
                        hasp_d = 1'b1;
                     end
                     else if (!c_ws)
                        perr = 1'b1;
                  end
                  exec = (c_sep | c_eoi) & ~perr & (pst_d == S_PAR);
               end
               // [R25] length digit count, then exact raw bytes
               S_BN:
               begin
                  if (c_dig & (c != `CH_ZERO))
                  begin
                     bdig_d = c[3:0];
                     blen_d = 16'h0000;
                     pst_d  = S_BL;
                  end
                  else
                     perr = 1'b1;
               end
               S_BL:
               begin
                  if (c_dig)
                  begin
                     blen_d = blen_x;
                     bdig_d = bdig_q - 4'h1;
                     if (bdig_q == 4'h1)
                        pst_d = (blen_x == 16'h0000) ? S_PAR : S_BD;
                  end
                  else
                     perr = 1'b1;
               end
               S_BD:
               begin
                  blen_d = blen_q - 16'h0001;
                  if (blen_q == 16'h0001)
                     pst_d = S_PAR;
               end
               S_SKIP:
               begin
                  if (c_sep)
                     pst_d = S_HDR;
               end
               default:
                  pst_d = S_HDR;
            endcase
            // [R24] newline or end flag terminates outside block data
            if (pst_q != S_BD)
               pterm = (c == `CH_NL) | c_eoi;
            // [R8] resume after the next separator
            if (perr)
               pst_d = pterm ? S_HDR : S_SKIP;
            if (exec | pterm)
               pst_d = S_HDR;
         end
      end
   end

   wire is_opc   = (hdr_d == `HDR_OPC);
   wire is_wai   = (hdr_d == `HDR_WAI);
   wire is_val   = (hdr_d == `HDR_VAL);
   wire is_empty = (hdr_d == 32'h0000_0000) & ~qry_d;
   wire cmd_opc  = exec & is_opc & ~qry_d;
   wire cmd_opcq = exec & is_opc & qry_d;
   wire cmd_wai  = exec & is_wai & ~qry_d;
   wire cmd_qval = exec & is_val & qry_d;
   wire cmd_sval = exec & is_val & ~qry_d & hasp_d;
   wire cmd_bad  = exec & ~(cmd_opc | cmd_opcq | cmd_wai | cmd_qval | cmd_sval | is_empty);
   wire clr_cmd  = exec | perr | pterm;

   always @(posedge clk_i)
   begin
      if (rst_i | dcl_i)
      begin
         pst_q  <= S_HDR;
         hdr_q  <= 32'h0000_0000;
         qry_q  <= 1'b0;
         val_q  <= 8'h00;
         hasp_q <= 1'b0;
         blen_q <= 16'h0000;
         bdig_q <= 4'h0;
      end
      else
      begin
         pst_q  <= pst_d;
         blen_q <= blen_d;
         bdig_q <= bdig_d;
         hdr_q  <= clr_cmd ? 32'h0000_0000 : hdr_d;
         qry_q  <= clr_cmd ? 1'b0 : qry_d;
         val_q  <= clr_cmd ? 8'h00 : val_d;
         hasp_q <= clr_cmd ? 1'b0 : hasp_d;
      end
   end

   // ----------------------------------------------------------------------------
   // settings store and apply
   // ----------------------------------------------------------------------------
   reg  dirty_q;
   reg  aplreq_q;
   reg  exe_err_q;
   // [R17] settled only once apply has gone through
   wire settled = hw_settled_i & ~hw_apply_o & ~aplreq_q;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hw_staged_o <= `RST_VALUE;
         hw_value_o  <= `RST_VALUE;
         dirty_q     <= 1'b0;
         aplreq_q    <= 1'b0;
         hw_apply_o  <= 1'b0;
         exe_err_q   <= 1'b0;
         trigger_o   <= 1'b0;
      end
      else
      begin
         // [R9] terminator or clear requests apply
         aplreq_q   <= (ipop & pterm) | dcl_i;
         hw_apply_o <= 1'b0;
         exe_err_q  <= 1'b0;
         trigger_o  <= trig;
         // [R10] check just before apply
         if (aplreq_q & dirty_q)
         begin
            if (hw_check_ok_i)
            begin
               hw_value_o <= hw_staged_o;
               hw_apply_o <= 1'b1;
            end
            else
               exe_err_q <= 1'b1;
         end
         // [R7] stage without applying
         if (cmd_sval)
         begin
            hw_staged_o <= val_d;
            dirty_q     <= 1'b1;
         end
         else if (aplreq_q & dirty_q)
         begin
            dirty_q <= 1'b0;
            // [R10] revert staged changes
            if (!hw_check_ok_i)
               hw_staged_o <= hw_value_o;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // synchronisation and response builder
   // ----------------------------------------------------------------------------
   reg  [12:0] ocnt_q;
   wire        opush   = (rn_q != 2'd0) & (ocnt_q != `OBUF_DEPTH);
   wire        opc_hit = opc_q & settled;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wai_q  <= 1'b0;
         opc_q  <= 1'b0;
         opcq_q <= 1'b0;
         rn_q   <= 2'd0;
         resp_q <= 24'h00_0000;
      end
      else
      begin
         // [R16] wait released by settled hardware
         if (cmd_wai)
            wai_q <= 1'b1;
         else if (settled)
            wai_q <= 1'b0;
         // [R14] event bit waits for settle
         if (cmd_opc)
            opc_q <= 1'b1;
         else if (settled)
            opc_q <= 1'b0;
         if (cmd_opcq)
            opcq_q <= 1'b1;
         // [R11] query value formatted as two hex digits and newline
         if (cmd_qval)
         begin
            resp_q <= {hexc(hw_staged_o[7:4]), hexc(hw_staged_o[3:0]), `CH_NL};
            rn_q   <= 2'd3;
         end
         // [R15] character 1 then newline, two bytes, after settle
         else if (opcq_q & settled & (rn_q == 2'd0))
         begin
            opcq_q <= 1'b0;
            resp_q <= {`CH_ONE, `CH_NL, 8'h00};
            rn_q   <= 2'd2;
         end
         else if (opush)
         begin
            resp_q <= {resp_q[15:0], 8'h00};
            rn_q   <= rn_q - 2'd1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // output buffer
   // ----------------------------------------------------------------------------
   reg  [7:0]  obuf [0:4095];
   reg  [11:0] owr_q;
   reg  [11:0] ord_q;
   // [R12] portions drain as the controller reads
   assign tx_valid_o = (ocnt_q != 13'h0000);
   wire        opop  = tx_valid_o & tx_ready_i;
   wire [11:0] ord_n = ord_q + {11'h000, opop};

   always @(posedge clk_i)
   begin
      if (opush)
         obuf[owr_q] <= resp_q[23:16];
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         owr_q     <= 12'h000;
         ord_q     <= 12'h000;
         ocnt_q    <= 13'h0000;
         tx_data_o <= 8'h00;
      end
      else
      begin
         if (opush)
            owr_q <= owr_q + 12'h001;
         ord_q  <= ord_n;
         ocnt_q <= ocnt_q + {12'h000, opush} - {12'h000, opop};
         if (opush & (owr_q == ord_n))
            tx_data_o <= resp_q[23:16];
         else
            tx_data_o <= obuf[ord_n];
      end
   end

   // ----------------------------------------------------------------------------
   // status reporting and register slave
   // ----------------------------------------------------------------------------
   reg  [7:0] esr_q;
   reg  [7:0] ese_q;
   reg  [7:0] sre_q;
   reg  [7:0] ppe_q;
   reg        talk_q;
   wire       wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wb_wr   = wb_req & wb_we_i & wb_sel_i[0];
   wire       esr_rd  = wb_req & ~wb_we_i & (wb_adr_i == `ADR_ESR);
   // [R13] talk with nothing buffered or coming
   wire       pending = (rn_q != 2'd0) | opcq_q | (avail_q != 9'h000);
   wire       qerr    = talk_i & ~talk_q & ~tx_valid_o & ~pending;
   wire [7:0] esr_set;
   wire [7:0] stb;
   // [R21] event summary into the status byte
   wire       esb     = |(esr_q & ese_q);
   // [R22] message available from buffer occupancy
   wire [7:0] stb_b   = {oper_sum_i, 1'b0, esb, tx_valid_o, ques_sum_i, 3'b000};
   wire       mss     = |(stb_b & sre_q & `STB_NO_MSS);

   // [R8] syntax error event
   assign esr_set = ({7'h00, opc_hit} << `ESR_OPC) | ({7'h00, qerr} << `ESR_QYE) |
                    ({7'h00, exe_err_q} << `ESR_EXE) | ({7'h00, perr | cmd_bad} << `ESR_CME);
   assign stb     = stb_b | ({7'h00, mss} << `STB_MSS);

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         esr_q    <= 8'h00;
         ese_q    <= `RST_MASK;
         sre_q    <= `RST_MASK;
         ppe_q    <= `RST_MASK;
         talk_q   <= 1'b0;
         srq_o    <= 1'b0;
         ist_o    <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         talk_q   <= talk_i;
         wb_ack_o <= wb_req;
         // [R14] hardware set wins over read clear
         esr_q    <= (esr_q & ~{8{esr_rd}}) | esr_set;
         srq_o    <= mss;
         // [R23] individual status through parallel poll mask
         ist_o    <= |(stb & ppe_q);
         if (wb_wr & (wb_adr_i == `ADR_ESE))
            ese_q <= wb_dat_i[7:0];
         if (wb_wr & (wb_adr_i == `ADR_SRE))
            sre_q <= wb_dat_i[7:0];
         if (wb_wr & (wb_adr_i == `ADR_PPE))
            ppe_q <= wb_dat_i[7:0];
         if (wb_req)
         begin
            case (wb_adr_i)
               `ADR_ESR:   wb_dat_o <= {24'h00_0000, esr_q};
               `ADR_ESE:   wb_dat_o <= {24'h00_0000, ese_q};
               `ADR_SRE:   wb_dat_o <= {24'h00_0000, sre_q};
               `ADR_PPE:   wb_dat_o <= {24'h00_0000, ppe_q};
               `ADR_STB:   wb_dat_o <= {24'h00_0000, stb};
               `ADR_STATE: wb_dat_o <= {12'h000, opcq_q, opc_q, wai_q, dirty_q, hw_staged_o, hw_value_o};
               default:    wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // gpib_cmd_pipeline

// ==== gpib_cmd_pipeline_props.sv ====
// port assertions for the command pipeline
`timescale 1ns/1ps
module gpib_cmd_pipeline_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rx_ready_o,
   input wire logic        get_i,
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_ready_i,
   input wire logic        hw_check_ok_i,
   input wire logic [7:0]  hw_staged_o,
   input wire logic [7:0]  hw_value_o,
   input wire logic        hw_apply_o,
   input wire logic        trigger_o,
   input wire logic        srq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----
   // checks
   // ----
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_get_stall: assert property (get_i |-> !rx_ready_o)
      else $error("byte taken beside trigger");
   a_apply_pulse: assert property (hw_apply_o |=> !hw_apply_o)
      else $error("apply longer than one cycle");
   a_apply_value: assert property (hw_apply_o && $past(hw_check_ok_i) |-> hw_value_o == $past(hw_staged_o))
      else $error("applied value not staged value");
   a_value_kept: assert property ($changed(hw_value_o) |-> hw_apply_o && $past(hw_check_ok_i))
      else $error("hardware value changed without good apply");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("response byte lost while stalled");
   a_trig_pulse: assert property (trigger_o |=> !trigger_o)
      else $error("trigger longer than one cycle");
   c_apply: cover property (hw_apply_o);
   c_trig: cover property (trigger_o);
   c_pop: cover property (tx_valid_o && tx_ready_i);
   c_srq: cover property ($rose(srq_o));
endmodule // gpib_cmd_pipeline_props

bind gpib_cmd_pipeline gpib_cmd_pipeline_props props (.*);

// ==== gpib_ctrl_model.sv ====
// bus controller model: sends program bytes, takes response bytes
`timescale 1ns/1ps
module gpib_ctrl_model (
   input  wire logic       clk_i,
   input  wire logic       rx_ready_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_eoi_o,
   output logic            tx_ready_o
);
   int hang = 0;
   initial {rx_valid_o, rx_data_o, rx_eoi_o, tx_ready_o} = '0;
   // end flag rides on the last byte
   task put(input logic [7:0] b, input logic e);
      int n;
      rx_valid_o <= 1'b1;
      rx_data_o <= b;
      rx_eoi_o <= e;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (rx_ready_i !== 1'b1 && n < 500);
      if (n >= 500) hang++;
   endtask
   // released line shows the inverse of the last byte
   task idle;
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
      rx_eoi_o <= 1'b0;
      @(posedge clk_i);
   endtask
   // string goes out byte by byte as given, end flag on its last byte if asked
   task send(input string s, input logic e);
      for (int i = 0; i < s.len(); i++) put(s[i], e && i == s.len() - 1);
      idle();
   endtask
   // response byte taken by raising ready until valid
   task get(input int gap, output logic [7:0] b);
      int n;
      repeat (gap) @(posedge clk_i);
      tx_ready_o <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (tx_valid_i !== 1'b1 && n < 500);
      b = tx_data_i;
      if (n >= 500) hang++;
      tx_ready_o <= 1'b0;
   endtask
endmodule // gpib_ctrl_model

// ==== gpib_cmd_pipeline_tb.sv ====
// testbench for the command pipeline
`timescale 1ns/1ps
module gpib_cmd_pipeline_tb;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_valid_i, rx_eoi_i, rx_ready_o;
   logic dcl_i, get_i, talk_i, tx_valid_o, tx_ready_i, hw_settled_i, hw_check_ok_i, hw_apply_o;
   logic trigger_o, oper_sum_i, ques_sum_i, srq_o, ist_o;
   logic [7:0] wb_adr_i, rx_data_i, tx_data_o, hw_staged_o, hw_value_o;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   int fail_count = 0;
   int checks_done = 0;
   logic [7:0] ws [4] = '{8'h00, 8'h09, 8'h0b, 8'h20};
   gpib_cmd_pipeline dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_data_i, .rx_eoi_i, .rx_ready_o, .dcl_i,
      .get_i, .talk_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .hw_settled_i, .hw_check_ok_i,
      .hw_staged_o, .hw_value_o, .hw_apply_o, .trigger_o, .oper_sum_i, .ques_sum_i, .srq_o, .ist_o);
   gpib_ctrl_model ctl (.clk_i, .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_eoi_o(rx_eoi_i), .tx_ready_o(tx_ready_i));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task summarize;
      fail_count += ctl.hang;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   function logic sig(int s);
      return s == 0 ? hw_apply_o : s == 1 ? tx_valid_o : s == 2 ? trigger_o : srq_o;
   endfunction
   task wt(input int s);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (sig(s) !== 1'b1 && n < 2000);
      if (n >= 2000) chk(32'h0000_0000, 32'h0000_0001);
      if (n >= 2000) summarize();
   endtask
   // ----
   // classic single cycle access
   // ----
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'h1};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 100);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge clk_i);
      if (n >= 100) chk(32'h0000_0000, 32'h0000_0001);
      if (n >= 100) summarize();
   endtask
   initial
   begin
      logic [31:0] q;
      logic [7:0] b;
      {rst_i, hw_settled_i, hw_check_ok_i} = 3'b111;
      {wb_cyc_i, wb_stb_i, wb_we_i, dcl_i, get_i, talk_i, oper_sum_i, ques_sum_i} = 8'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a <= 24; a += 4)
      begin
         wb(1'b0, a[7:0], 32'h0000_0000, q);
         chk(q, 32'h0000_0000);
      end
      wb(1'b1, 8'h04, 32'h0000_0001, q);
      wb(1'b1, 8'h08, 32'h0000_0020, q);
      wb(1'b1, 8'h0c, 32'h0000_0010, q);
      wb(1'b0, 8'h08, 32'h0000_0000, q);
      chk(q, 32'h0000_0020);
      ctl.send("VAL 5\n", 1'b0);
      wt(0);
      chk(hw_value_o, 8'h05);
      {oper_sum_i, ques_sum_i} <= 2'b11;
      ctl.send("VAL?\n", 1'b0);
      wt(1);
      wb(1'b0, 8'h10, 32'h0000_0000, q);
      chk(q, 32'h0000_0098);
      chk(ist_o, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         ctl.get(3, b);
         chk(b, 8'("05\n" >> (8 * (2 - i))));
      end
      talk_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      talk_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      chk(q, 32'h0000_0004);
      chk(tx_valid_o, 1'b0);
      ctl.send("FOO;VAL 9\n", 1'b0);
      wt(0);
      chk(hw_value_o, 8'h09);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      chk(q, 32'h0000_0020);
      hw_check_ok_i <= 1'b0;
      ctl.send("VAL 7\n", 1'b0);
      repeat (20) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      chk(q, 32'h0000_0010);
      chk({hw_value_o, hw_staged_o}, 16'h0909);
      hw_check_ok_i <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         ctl.send("VAL", 1'b0);
         ctl.put(ws[k], 1'b0);
         ctl.put(8'h31 + k[7:0], 1'b0);
         ctl.put(8'h0a, 1'b0);
         ctl.idle();
         wt(0);
         chk(hw_value_o, 8'h01 + k[7:0]);
      end
      ctl.send("VAL 6", 1'b1);
      wt(0);
      chk(hw_value_o, 8'h06);
      ctl.send("VAL 8\n", 1'b0);
      get_i <= 1'b1;
      @(posedge clk_i);
      get_i <= 1'b0;
      wt(2);
      chk(hw_staged_o, 8'h08);
      ctl.send("VAL 3", 1'b0);
      dcl_i <= 1'b1;
      @(posedge clk_i);
      dcl_i <= 1'b0;
      ctl.send("\n", 1'b0);
      repeat (20) @(posedge clk_i);
      chk(hw_value_o, 8'h08);
      ctl.send("*OPC?\n", 1'b0);
      ctl.get(1, b);
      chk(b, 8'h31);
      ctl.get(2, b);
      chk(b, 8'h0a);
      hw_settled_i <= 1'b0;
      ctl.send("*OPC\n", 1'b0);
      repeat (20) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      hw_settled_i <= 1'b1;
      wt(3);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      chk(q, 32'h0000_0001);
      hw_settled_i <= 1'b0;
      ctl.send("*WAI\n", 1'b0);
      repeat (20) @(posedge clk_i);
      chk(rx_ready_o, 1'b0);
      hw_settled_i <= 1'b1;
      ctl.send("VAL 2 #12\n;\n", 1'b0);
      wt(0);
      chk(hw_value_o, 8'h02);
      summarize();
   end
endmodule // gpib_cmd_pipeline_tb
